// ===== core/host_serial_port.sv
// Host-facing serial port with hardware flow control and modem status lines.
// Assumes the strobe register port runs on core_clk; all pins are asynchronous.
//
// Notes on behaviour
// - Serial port: transmit, receive, two handshake lines.
// - Selectable baud divisor, parity none/even/odd.
// - Power-up settings loaded from nonvolatile inputs.
// - Flow control both directions via handshakes.
// - Request output and clear input are active low.
// - Ring line signals calls; pollable by setting.
// - Data-set-ready drop: hang up or command mode.
// - Host sends into receive; device returns on transmit.
// - Sustained payload held under the throughput limit.
// - Ring output low when remote starts connection.
// - Carrier output low while connection is live.
// - Baud divisor covers the lowest rate; divisor 1 gives only 625000 baud, below the highest.
// - Terminal-ready active low, shared with general pin.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module host_serial_port
  import serial_port_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              nv_valid,
  input  wire logic [15:0]       nv_baud_div,
  input  wire logic [1:0]        nv_parity,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  output logic                   irq,
  input  wire logic              serial_rx,
  output logic                   serial_tx,
  output logic                   rts_n,
  input  wire logic              cts_n,
  input  wire logic              dsr_n,
  input  wire logic              incoming_call_in,
  output logic                   incoming_call_out_n,
  output logic                   incoming_call_oe,
  output logic                   link_live_out_n,
  output logic                   dtr_gpio_out,
  output logic                   dtr_gpio_oe,
  output logic                   hangup_pulse,
  output logic                   cmd_mode_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] rx_s_q, cts_s_q, dsr_s_q, ri_s_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s_q  <= 2'h3;
      cts_s_q <= 2'h3;
      dsr_s_q <= 2'h3;
      ri_s_q  <= 2'h0;
    end else begin
      rx_s_q  <= {rx_s_q[0], serial_rx};
      cts_s_q <= {cts_s_q[0], cts_n};
      dsr_s_q <= {dsr_s_q[0], dsr_n};
      ri_s_q  <= {ri_s_q[0], incoming_call_in};
    end
  end
  logic rx_i, cts_ok, dsr_on;
  assign rx_i   = rx_s_q[1];
  assign cts_ok = ~cts_s_q[1];
  assign dsr_on = ~dsr_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       div_q;
  logic              loaded_q;
  logic [EV_W-1:0]   mask_q;
  logic [1:0]        par_mode;
  assign par_mode = ctrl_q[CTRL_PAR_HI:CTRL_PAR_LO];

  // Defaults are caught from the store once after release, never under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= '0;
      div_q    <= DIV_DEFAULT;
      loaded_q <= 1'b0;
    end else begin
      if (!loaded_q && nv_valid) begin
        loaded_q                         <= 1'b1;
        div_q                            <= nv_baud_div;
        ctrl_q[CTRL_PAR_HI:CTRL_PAR_LO]  <= nv_parity;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_q <= reg_wdata[CTRL_W-1:0];
      end else if (reg_wr && reg_addr == REG_BAUD) begin
        div_q <= (reg_wdata == 16'h0) ? 16'h1 : reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mask_q <= '0;
    else if (reg_wr && reg_addr == REG_MASK) mask_q <= reg_wdata[EV_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud tick at sixteen times the bit rate

  logic [15:0] bcnt_q;
  logic        tick;
  assign tick = (bcnt_q == 16'h0);
  // A divisor written to REG_BAUD restarts the prescaler, else a long old count would hold off the new rate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) bcnt_q <= '0;
    else if (reg_wr && reg_addr == REG_BAUD) bcnt_q <= '0;
    else bcnt_q <= tick ? div_q - 16'h1 : bcnt_q - 16'h1;
  end

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] m);
    par_bit = (m == PAR_ODD) ? ~^d : ^d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_st_e;
  tx_st_e      tx_st_q;
  logic [7:0]  tx_hold_q, tx_sh_q;
  logic        tx_full_q, tx_done;
  logic [3:0]  tx_sub_q;
  logic [2:0]  tx_bit_q;
  logic [15:0] gap_q;
  wire         tx_take = reg_wr && reg_addr == REG_TXDATA && !tx_full_q;
  wire         sub_end = tick && tx_sub_q == 4'hf;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= TX_IDLE; tx_full_q <= 1'b0; tx_hold_q <= '0; tx_sh_q <= '0;
      tx_sub_q <= '0; tx_bit_q <= '0; serial_tx <= 1'b1; gap_q <= '0;
    end else begin
      if (tx_take) begin
        tx_hold_q <= reg_wdata[7:0];
        tx_full_q <= 1'b1;
      end
      if (gap_q != 16'h0) gap_q <= gap_q - 16'h1;
      if (tick && tx_st_q != TX_IDLE) tx_sub_q <= tx_sub_q + 4'h1;
      case (tx_st_q)
        TX_IDLE: if (tx_full_q && cts_ok && gap_q == 16'h0 && tick) begin
          tx_st_q   <= TX_START;
          tx_sh_q   <= tx_hold_q;
          tx_full_q <= 1'b0;
          tx_sub_q  <= 4'h0;
          serial_tx <= 1'b0;
          gap_q     <= 16'(THRU_GAP_CYC);
        end
        TX_START: if (sub_end) begin
          tx_st_q <= TX_DATA; tx_bit_q <= 3'h0; serial_tx <= tx_sh_q[0];
        end
        TX_DATA: if (sub_end) begin
          if (tx_bit_q == 3'h7) begin
            tx_st_q   <= (par_mode == PAR_NONE) ? TX_STOP : TX_PAR;
            serial_tx <= (par_mode == PAR_NONE) ? 1'b1 : par_bit(tx_sh_q, par_mode);
          end else begin
            tx_bit_q  <= tx_bit_q + 3'h1;
            serial_tx <= tx_sh_q[tx_bit_q + 3'h1];
          end
        end
        TX_PAR:  if (sub_end) begin tx_st_q <= TX_STOP; serial_tx <= 1'b1; end
        TX_STOP: if (sub_end) tx_st_q <= TX_IDLE;
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  assign tx_done = (tx_st_q == TX_STOP) && sub_end;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver, one holding byte; request is withdrawn while it is occupied

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_st_e;
  rx_st_e     rx_st_q;
  logic [7:0] rx_sh_q, rx_buf_q;
  logic       rx_full_q, rx_pbit_q;
  logic [3:0] rx_sub_q;
  logic [2:0] rx_bit_q;
  logic       ev_rx, ev_perr, ev_ferr, ev_ovr;
  wire        rx_pop  = reg_rd && reg_addr == REG_RXDATA;
  wire        rx_mid  = tick && rx_sub_q == 4'h7;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE; rx_sh_q <= '0; rx_buf_q <= '0; rx_full_q <= 1'b0;
      rx_sub_q <= '0; rx_bit_q <= '0; rx_pbit_q <= 1'b0; rts_n <= 1'b1;
      ev_rx <= 1'b0; ev_perr <= 1'b0; ev_ferr <= 1'b0; ev_ovr <= 1'b0;
    end else begin
      ev_rx <= 1'b0; ev_perr <= 1'b0; ev_ferr <= 1'b0; ev_ovr <= 1'b0;
      if (rx_pop) rx_full_q <= 1'b0;
      if (tick && rx_st_q != RX_IDLE) rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: if (tick && !rx_i) begin rx_st_q <= RX_START; rx_sub_q <= 4'h0; end
        RX_START: if (rx_mid) begin
          rx_st_q <= rx_i ? RX_IDLE : RX_DATA;                      // glitch reject
          rx_bit_q <= 3'h0; rx_sub_q <= 4'h8;
        end
        RX_DATA: if (rx_mid) begin
          rx_sh_q  <= {rx_i, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) rx_st_q <= (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
        end
        RX_PAR: if (rx_mid) begin rx_pbit_q <= rx_i; rx_st_q <= RX_STOP; end
        RX_STOP: if (rx_mid) begin
          rx_st_q <= RX_IDLE;
          ev_ferr <= !rx_i;
          ev_perr <= (par_mode != PAR_NONE) && (rx_pbit_q != par_bit(rx_sh_q, par_mode));
          ev_ovr  <= rx_full_q && !rx_pop;
          ev_rx   <= 1'b1;
          rx_buf_q  <= rx_sh_q;
          rx_full_q <= 1'b1;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
      // Drop request whenever the holder is full and is not being read this cycle
      rts_n <= rx_full_q && !rx_pop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem status lines

  logic     dsr_prev_q;
  dsr_act_e dsr_act;
  always_comb begin
    dsr_act = DSR_KEEP;
    if (ctrl_q[CTRL_HS] && ctrl_q[CTRL_LIVE] && dsr_prev_q && !dsr_on)
      dsr_act = ctrl_q[CTRL_DSR_CMD] ? DSR_CMD : DSR_DROP;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsr_prev_q <= 1'b0; hangup_pulse <= 1'b0; cmd_mode_pulse <= 1'b0;
      incoming_call_out_n <= 1'b1; incoming_call_oe <= 1'b1; link_live_out_n <= 1'b1;
      dtr_gpio_out <= 1'b1; dtr_gpio_oe <= 1'b1;
    end else begin
      dsr_prev_q          <= dsr_on;
      hangup_pulse        <= (dsr_act == DSR_DROP);
      cmd_mode_pulse      <= (dsr_act == DSR_CMD);
      // Polled mode turns the ring pin around so incoming activity is sensed
      incoming_call_oe    <= !ctrl_q[CTRL_RI_POLL];
      incoming_call_out_n <= !ctrl_q[CTRL_RING];
      link_live_out_n     <= !(ctrl_q[CTRL_LIVE] && dsr_act != DSR_DROP);
      dtr_gpio_oe         <= 1'b1;
      dtr_gpio_out        <= ctrl_q[CTRL_DTR_GPIO] ? ctrl_q[CTRL_GPIO_V] : !ctrl_q[CTRL_DTR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, interrupt and read port

  logic [EV_W-1:0] stat_q, ev_vec;
  assign ev_vec = {dsr_act == DSR_DROP || dsr_act == DSR_CMD, ev_ovr, ev_ferr, ev_perr, tx_done, ev_rx};
  wire stat_rd = reg_rd && reg_addr == REG_STAT;

  // New events win over the clear that a status read performs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) stat_q <= '0;
    else stat_q <= (stat_rd ? '0 : stat_q) | ev_vec;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else irq <= |(((stat_rd ? '0 : stat_q) | ev_vec) & mask_q);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= '0;
    else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   reg_rdata <= 16'(ctrl_q);
        REG_BAUD:   reg_rdata <= div_q;
        REG_STAT:   reg_rdata <= 16'(stat_q);
        REG_MASK:   reg_rdata <= 16'(mask_q);
        REG_TXDATA: reg_rdata <= {15'h0, tx_full_q};
        REG_RXDATA: reg_rdata <= {8'h0, rx_buf_q};
        REG_LINES:  reg_rdata <= {10'h0, ri_s_q[1], loaded_q, rx_full_q, dsr_on, cts_ok, rx_i};
        default:    reg_rdata <= 16'h0;
      endcase
    end else reg_rdata <= 16'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_drop_seen;
    ctrl_q[CTRL_HS] && ctrl_q[CTRL_LIVE] && !ctrl_q[CTRL_DSR_CMD] && dsr_prev_q && !dsr_on;
  endsequence

  a_tx_needs_cts:  assert property (@(posedge core_clk) disable iff (!rst_n)
    (tx_st_q == TX_IDLE ##1 tx_st_q == TX_START) |-> $past(cts_ok)) else $error("start without clear");
  a_start_low:     assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(tx_st_q == TX_START) |-> !serial_tx) else $error("start bit not low");
  a_rts_full:      assert property (@(posedge core_clk) disable iff (!rst_n)
    (rx_full_q && !rx_pop) |=> rts_n) else $error("request while buffer full");
  a_dsr_hangup:    assert property (@(posedge core_clk) disable iff (!rst_n)
    s_drop_seen |=> hangup_pulse ##0 link_live_out_n) else $error("no hangup on drop");
  a_dsr_cmd:       assert property (@(posedge core_clk) disable iff (!rst_n)
    (dsr_act == DSR_CMD) |=> cmd_mode_pulse && !hangup_pulse) else $error("no command mode");
  a_live_line:     assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_q[CTRL_LIVE] |=> link_live_out_n) else $error("carrier without link");
  a_ring_line:     assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_q[CTRL_RING] |=> !incoming_call_out_n) else $error("ring not driven");
  a_idle_high:     assert property (@(posedge core_clk) disable iff (!rst_n)
    (tx_st_q == TX_IDLE) |-> serial_tx) else $error("line not idle high");
  a_rate_gap:      assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(tx_st_q == TX_START) |-> gap_q == 16'(THRU_GAP_CYC)) else $error("gap not armed");

endmodule
`default_nettype wire

// ===== core/serial_port_pkg.sv
// Constants shared by the host serial port: register map, field layout, timing.
// Assumes a 10 MHz core clock and a plain strobe register port.
package serial_port_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned BAUD_MIN      = 1200;
  localparam int unsigned BAUD_MAX      = 921_600;
  localparam int unsigned THRU_BPS      = 300_000;
  // Least spacing between payload bytes so the sustained rate stays under the limit
  localparam int unsigned THRU_GAP_CYC  = (CLK_HZ * 8 + THRU_BPS - 1) / THRU_BPS;

  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_BAUD      = 4'h1;
  localparam logic [3:0]  REG_STAT      = 4'h2;
  localparam logic [3:0]  REG_MASK      = 4'h3;
  localparam logic [3:0]  REG_TXDATA    = 4'h4;
  localparam logic [3:0]  REG_RXDATA    = 4'h5;
  localparam logic [3:0]  REG_LINES     = 4'h6;

  // Control register fields
  localparam int unsigned CTRL_PAR_LO   = 0;
  localparam int unsigned CTRL_PAR_HI   = 1;
  localparam int unsigned CTRL_HS       = 2;
  localparam int unsigned CTRL_DSR_CMD  = 3;
  localparam int unsigned CTRL_RI_POLL  = 4;
  localparam int unsigned CTRL_DTR_GPIO = 5;
  localparam int unsigned CTRL_GPIO_V   = 6;
  localparam int unsigned CTRL_RING     = 7;
  localparam int unsigned CTRL_LIVE     = 8;
  localparam int unsigned CTRL_DTR      = 9;
  localparam int unsigned CTRL_W        = 10;

  localparam logic [1:0]  PAR_NONE      = 2'h0;
  localparam logic [1:0]  PAR_EVEN      = 2'h1;
  localparam logic [1:0]  PAR_ODD       = 2'h2;

  // Status / interrupt bits
  localparam int unsigned EV_RX         = 0;
  localparam int unsigned EV_TXDONE     = 1;
  localparam int unsigned EV_PERR       = 2;
  localparam int unsigned EV_FERR       = 3;
  localparam int unsigned EV_OVR        = 4;
  localparam int unsigned EV_DSR_DROP   = 5;
  localparam int unsigned EV_W          = 6;

  localparam int unsigned DIV_W         = 16;
  localparam logic [15:0] DIV_DEFAULT   = 16'(CLK_HZ / (16 * 9600));

  typedef enum logic [1:0] {
    DSR_KEEP,
    DSR_DROP,
    DSR_CMD
  } dsr_act_e;

endpackage

// ===== test/host_model.sv
// Host side UART model: drives the device receive pin and decodes the device transmit pin.
// Assumes the same clock as the bench and a divisor of 1, so one bit lasts BIT_CYC cycles.
`timescale 1ns/10ps
`default_nettype none
module host_model
  import serial_port_pkg::*;
#(
  parameter int BIT_CYC = 16
)
(
  input  wire logic core_clk,
  input  wire logic serial_tx,
  input  wire logic rts_n,
  output var logic  serial_rx,
  output wire logic cts_n
);
  logic [1:0] par_mode = PAR_NONE;
  logic       pause    = 1'b0;
  logic [7:0] rx_q[$];
  logic       rx_p[$];
  logic       rx_s[$];
  int         rx_t[$];
  int         cyc      = 0;
  logic [7:0] d;
  logic       p;
  logic       s;
  int         t;
  always @(posedge core_clk) cyc <= cyc + 1;
  assign cts_n = pause;  // Low grants the device leave to send
  initial serial_rx = 1'b1;  // Line idles high
  //////////////////////////////////////////////////////////////////////////////
  // A real host would not wait forever on a stuck handshake; bounded here
  task automatic send(input logic [7:0] b, input logic bad);
    int n;
    n = 0;
    while (rts_n !== 1'b0 && n < 5000) begin  // Holds back while device refuses
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    serial_rx <= 1'b0;  // Start bit into the device receive pin
    repeat (BIT_CYC) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      serial_rx <= b[i];  // Least significant bit first
      repeat (BIT_CYC) @(posedge core_clk);
    end
    if (par_mode != PAR_NONE) begin
      serial_rx <= ((par_mode == PAR_EVEN) ? ^b : ~^b) ^ bad;
      repeat (BIT_CYC) @(posedge core_clk);
    end
    serial_rx <= 1'b1;  // Stop bit, then idle
    repeat (BIT_CYC) @(posedge core_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Samples mid-bit, so a start pulse shorter than half a bit is dropped
  always begin
    @(negedge serial_tx);
    t = cyc;
    repeat (BIT_CYC / 2) @(posedge core_clk);
    if (serial_tx === 1'b0) begin  // Frame decode
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        d[i] = serial_tx;
      end
      p = 1'b0;
      if (par_mode != PAR_NONE) begin
        repeat (BIT_CYC) @(posedge core_clk);
        p = serial_tx;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      s = serial_tx;
      rx_q.push_back(d);
      rx_p.push_back(p);
      rx_s.push_back(s);
      rx_t.push_back(t);
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the host serial port: registers, both data directions, modem lines.
// Assumes host_model on the serial pins; the bench itself plays the data-set-ready line into dsr_n.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import serial_port_pkg::*;
;
  localparam int LIMIT = 40000;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        dsr_n     = 1'b0;
  logic        call_in   = 1'b0;
  logic [15:0] reg_rdata;
  logic        irq, serial_rx, serial_tx, rts_n, cts_n, ring_n, ring_oe, live_n, dtr_out, dtr_oe, hang, cmd;
  logic [15:0] v;
  logic [7:0]  b;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          n_hang     = 0;
  int          n_cmd      = 0;
  int          n;
  always #50 core_clk = ~core_clk;
  host_serial_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .nv_valid(1'b1), .nv_baud_div(16'h0003),
    .nv_parity(PAR_ODD), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .serial_rx(serial_rx), .serial_tx(serial_tx), .rts_n(rts_n),
    .cts_n(cts_n), .dsr_n(dsr_n), .incoming_call_in(call_in), .incoming_call_out_n(ring_n),
    .incoming_call_oe(ring_oe), .link_live_out_n(live_n), .dtr_gpio_out(dtr_out), .dtr_gpio_oe(dtr_oe),
    .hangup_pulse(hang), .cmd_mode_pulse(cmd));
  host_model host_u (.core_clk(core_clk), .serial_tx(serial_tx), .rts_n(rts_n), .serial_rx(serial_rx),
    .cts_n(cts_n));
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    n_hang <= n_hang + int'(hang === 1'b1);
    n_cmd <= n_cmd + int'(cmd === 1'b1);
    if (cyc == LIMIT) begin
      num_errors++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just past that edge
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string nm);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(nm, e, v & m);
  endtask
  task automatic wait_rx(input int k);
    for (int i = 0; i < 4000 && host_u.rx_q.size() < k; i++) @(posedge core_clk);
  endtask
  function automatic logic par_of(input logic [7:0] x, input logic [1:0] m);
    return (m == PAR_EVEN) ? ^x : ~^x;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hd8ed));
    repeat (6) @(posedge core_clk);
    #1 chk("idle", 16'h000f, {irq, serial_tx, rts_n, ring_n, live_n});
    rst_n <= 1'b1;
    rd(REG_BAUD, 16'hffff, 16'h0003, "nv_baud");
    rd(REG_CTRL, 16'h0003, {14'h0, PAR_ODD}, "nv_par");
    rd(REG_LINES, 16'h0010, 16'h0010, "loaded");
    rd(4'hf, 16'hffff, 16'h0000, "unmapped");
    wr(REG_BAUD, 16'hffff);
    rd(REG_BAUD, 16'hffff, 16'hffff, "baud_max");
    wr(REG_BAUD, 16'h0000);
    rd(REG_BAUD, 16'hffff, 16'h0001, "baud_zero");
    wr(REG_MASK, 16'h003f);
    for (int k = 0; k < 6; k++) begin
      host_u.par_mode = 2'(k / 2);
      wr(REG_CTRL, {14'h0, 2'(k / 2)});
      b = (k == 0) ? 8'hff : 8'($urandom);
      n = host_u.rx_q.size();
      wr(REG_TXDATA, {8'h0, b});
      wait_rx(n + 1);
      chk("tx_byte", {8'h0, b}, {8'h0, host_u.rx_q[n]});
      chk("tx_stop", 1, host_u.rx_s[n]);
      if (k > 1) chk("tx_par", par_of(b, 2'(k / 2)), host_u.rx_p[n]);
      b = (k == 1) ? 8'h00 : 8'($urandom);
      host_u.send(b, 1'b0);
      repeat (20) @(posedge core_clk);
      chk("irq_rx", 1, irq);
      chk("rts_full", 1, rts_n);
      rd(REG_STAT, 16'h0005, 16'h0001, "stat_rx");
      rd(REG_RXDATA, 16'h00ff, {8'h0, b}, "rx_byte");
      repeat (2) @(posedge core_clk);
      chk("rts_free", 0, rts_n);
    end
    host_u.par_mode = PAR_NONE;
    wr(REG_CTRL, 16'h0000);
    n = host_u.rx_q.size();
    wr(REG_TXDATA, 16'h00a5);
    for (int i = 0; i < 500; i++) begin
      rd(REG_TXDATA, 16'hfffe, 16'h0000, "poll");
      if (v[0] === 1'b0) break;
    end
    wr(REG_TXDATA, 16'h003c);
    wait_rx(n + 2);
    chk("tx_second", 16'h003c, {8'h0, host_u.rx_q[n + 1]});
    chk("tx_gap", 1, host_u.rx_t[n + 1] - host_u.rx_t[n] >= THRU_GAP_CYC);
    host_u.pause <= 1'b1;
    n = host_u.rx_q.size();
    wr(REG_TXDATA, 16'h00c3);
    repeat (600) @(posedge core_clk);
    chk("cts_hold", n, host_u.rx_q.size());
    host_u.pause <= 1'b0;
    wait_rx(n + 1);
    chk("cts_go", 16'h00c3, {8'h0, host_u.rx_q[n]});
    wr(REG_MASK, 16'h0000);
    wr(REG_CTRL, {14'h0, PAR_EVEN});
    host_u.par_mode = PAR_EVEN;
    host_u.send(8'h81, 1'b1);
    repeat (20) @(posedge core_clk);
    chk("irq_masked", 0, irq);
    wr(REG_MASK, 16'h0004);
    repeat (2) @(posedge core_clk);
    chk("irq_unmask", 1, irq);
    rd(REG_STAT, 16'h0004, 16'h0004, "perr");
    repeat (2) @(posedge core_clk);
    chk("irq_clear", 0, irq);
    rd(REG_RXDATA, 16'h00ff, 16'h0081, "drain");
    for (int k = 7; k <= 9; k++) begin
      wr(REG_CTRL, 16'(1 << k));
      repeat (2) @(posedge core_clk);
      chk("modem", {13'h0, k != 7, k != 8, k != 9}, {13'h0, ring_n, live_n, dtr_out});
    end
    wr(REG_CTRL, 16'h0260);
    repeat (2) @(posedge core_clk);
    chk("gpio_hi", 1, dtr_out);
    wr(REG_CTRL, 16'h0020);
    repeat (2) @(posedge core_clk);
    chk("gpio_lo", 0, dtr_out);
    chk("gpio_oe", 1, dtr_oe);
    call_in <= 1'b1;
    wr(REG_CTRL, 16'h0010);
    repeat (4) @(posedge core_clk);
    chk("poll_oe", 0, ring_oe);
    rd(REG_LINES, 16'h0020, 16'h0020, "ring_hi");
    call_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(REG_LINES, 16'h0020, 16'h0000, "ring_lo");
    for (int k = 0; k < 3; k++) begin
      n = n_hang + 2 * n_cmd;
      wr(REG_CTRL, (k == 2) ? 16'h0100 : 16'(16'h0104 | (k << 3)));
      dsr_n <= 1'b1;  // Host drops data-set-ready
      repeat (10) @(posedge core_clk);
      chk("dsr_act", (k == 2) ? n : n + k + 1, n_hang + 2 * n_cmd);
      if (k < 2) rd(REG_STAT, 16'h0020, 16'h0020, "dsr_stat");
      dsr_n <= 1'b0;
      repeat (10) @(posedge core_clk);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
